//--- mdv_mul_div_unit.sv
// multiply/divide unit with a classic wishbone register slave
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`include "mdv_params.svh"
`timescale 1ns/100ps
`default_nettype none

module mdv_mul_div_unit
    import mdv_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [`MDV_ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic stb_i,
    input wire logic cyc_i,
    output logic ack_o
);

    // ======================================================================
    // helpers
    function automatic mdv_seq_e seqStep(input mdv_seq_e s, input logic [2:0] i);
        seqStep = (i == 3'd0) ? SEQ_W0 : SEQ_NONE;
        unique case (s)
            SEQ_W0: begin
                if (i == 3'd1) seqStep = SEQ_W01;
                else if (i == 3'd4) seqStep = SEQ_W04;
            end
            SEQ_W01: begin
                if (i == 3'd2) seqStep = SEQ_W012;
                else if (i == 3'd4) seqStep = SEQ_W014;
            end
            SEQ_W012: begin
                if (i == 3'd3) seqStep = SEQ_W0123;
            end
            SEQ_W0123: begin
                if (i == 3'd4) seqStep = SEQ_W01234;
            end
            SEQ_W04: begin
                if (i == 3'd1) seqStep = SEQ_W041;
            end
            SEQ_NONE, SEQ_W01234, SEQ_W014, SEQ_W041: begin
            end
        endcase
    endfunction

    // quotient in the upper 32 bits, remainder in the lower 16
    function automatic logic [47:0] divide(input logic [31:0] n, input logic [15:0] d);
        logic [31:0] q;
        logic [31:0] r;
        q = 32'hffff_ffff;
        r = n;
        if (d != 16'h0000) begin
            q = n / {16'h0000, d};
            r = n % {16'h0000, d};
        end
        divide = {q, r[15:0]};
    endfunction

    function automatic logic [`MDV_CNT_W-1:0] cycOf(input mdv_op_e o);
        unique case (o)
            OP_DIV32: cycOf = `MDV_CNT_W'(`MDV_CYC(`MDV_DIV32_SYSTEM_CLOCK_PERIOD));
            OP_DIV16: cycOf = `MDV_CNT_W'(`MDV_CYC(`MDV_DIV16_SYSTEM_CLOCK_PERIOD));
            OP_MUL: cycOf = `MDV_CNT_W'(`MDV_CYC(`MDV_MUL_SYSTEM_CLOCK_PERIOD));
        endcase
    endfunction

    // ======================================================================
    // state
    logic [7:0] opReg [`MDV_NUM_BYTES];
    logic [7:0] next_opReg [`MDV_NUM_BYTES];
    mdv_seq_e seq, next_seq;
    mdv_op_e op, next_op;
    logic busy, next_busy;
    logic [`MDV_CNT_W-1:0] cnt, next_cnt;
    logic errFlag, next_errFlag;
    logic ovfFlag, next_ovfFlag;
    logic next_ack;
    logic [31:0] next_dat;

    logic req;
    logic hitOp;
    logic hitStat;
    logic wrOp;
    logic done;
    logic [2:0] idx;
    logic [31:0] mulProd;
    logic [47:0] div32Res;
    logic [47:0] div16Res;
    logic [15:0] divisor;

    // ======================================================================
    // bus decode
    assign req = cyc_i & stb_i & ~ack_o;
    assign idx = adr_i[4:2];
    assign hitOp = req && (adr_i < `MDV_OFS_STATUS) && (adr_i[1:0] == 2'b00);
    assign hitStat = req && (adr_i == `MDV_OFS_STATUS);
    // operand writes are dropped while busy so the running calculation stays intact
    assign wrOp = hitOp & we_i & sel_i[0] & ~busy;
    assign done = busy && (cnt == '0);

    // ======================================================================
    // arithmetic, byte 0 least significant
    assign divisor = {opReg[5], opReg[4]};
    assign mulProd = {opReg[1], opReg[0]} * {opReg[5], opReg[4]};
    assign div32Res = divide({opReg[3], opReg[2], opReg[1], opReg[0]}, divisor);
    assign div16Res = divide({16'h0000, opReg[1], opReg[0]}, divisor);

    // ======================================================================
    // sequencer and datapath
    always_comb begin
        next_opReg = opReg;
        next_seq = seq;
        next_op = op;
        next_busy = busy;
        next_cnt = cnt;
        next_errFlag = errFlag;
        next_ovfFlag = ovfFlag;
        if (wrOp) begin
            next_opReg[idx] = dat_i[7:0];
            next_seq = seqStep(seq, idx);
            if (idx == 3'd5) begin
                next_seq = SEQ_NONE;
                // only a byte5 write closing a known sequence starts work
                if (seq == SEQ_W01234) begin
                    next_busy = 1'b1;
                    next_op = OP_DIV32;
                    next_cnt = cycOf(OP_DIV32) - `MDV_CNT_W'(1);
                end else if (seq == SEQ_W014) begin
                    next_busy = 1'b1;
                    next_op = OP_DIV16;
                    next_cnt = cycOf(OP_DIV16) - `MDV_CNT_W'(1);
                end else if (seq == SEQ_W041) begin
                    next_busy = 1'b1;
                    next_op = OP_MUL;
                    next_cnt = cycOf(OP_MUL) - `MDV_CNT_W'(1);
                end
            end
        end
        if (busy) begin
            next_cnt = cnt - `MDV_CNT_W'(1);
            if (done) begin
                next_busy = 1'b0;
                next_cnt = '0;
                unique case (op)
                    OP_DIV32: begin
                        {next_opReg[3], next_opReg[2], next_opReg[1], next_opReg[0]} = div32Res[47:16];
                        {next_opReg[5], next_opReg[4]} = div32Res[15:0];
                        next_ovfFlag = (divisor == 16'h0000);
                    end
                    OP_DIV16: begin
                        {next_opReg[1], next_opReg[0]} = div16Res[31:16];
                        {next_opReg[5], next_opReg[4]} = div16Res[15:0];
                        next_ovfFlag = (divisor == 16'h0000);
                    end
                    OP_MUL: begin
                        {next_opReg[3], next_opReg[2], next_opReg[1], next_opReg[0]} = mulProd;
                        next_ovfFlag = (mulProd[31:16] != 16'h0000);
                    end
                endcase
            end
        end
        // clear first so a same-cycle set wins
        if (hitStat && !we_i && errFlag && !busy) begin
            next_errFlag = 1'b0;
        end
        if (hitOp && busy) begin
            next_errFlag = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `MDV_NUM_BYTES; i++) begin
                opReg[i] <= `MDV_BYTE_RESET;
            end
            seq <= SEQ_NONE;
            op <= OP_DIV32;
            busy <= 1'b0;
            cnt <= '0;
            errFlag <= 1'(`MDV_STATUS_RESET >> `MDV_BIT_ERR);
            ovfFlag <= 1'b0;
        end else begin
            opReg <= next_opReg;
            seq <= next_seq;
            op <= next_op;
            busy <= next_busy;
            cnt <= next_cnt;
            errFlag <= next_errFlag;
            ovfFlag <= next_ovfFlag;
        end
    end

    // ======================================================================
    // bus answer: one wait state, unmapped reads return zero
    always_comb begin
        next_ack = req;
        next_dat = 32'h0000_0000;
        if (hitOp && !we_i) begin
            next_dat = {24'h00_0000, opReg[idx]};
        end else if (hitStat && !we_i) begin
            next_dat = {24'h00_0000, errFlag, ovfFlag, 6'b00_0000};
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= next_ack;
            dat_o <= next_dat;
        end
    end

    // ======================================================================
    // checks
    logic [`MDV_CNT_W:0] runLen;
    logic [47:0] opFlat;
    assign opFlat = {opReg[5], opReg[4], opReg[3], opReg[2], opReg[1], opReg[0]};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            runLen <= '0;
        end else begin
            runLen <= busy ? runLen + (`MDV_CNT_W+1)'(1) : '0;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // runLen still holds the full count in the cycle busy is seen low
    a_calc_length: assert property ($fell(busy) |-> runLen == {1'b0, cycOf(op)})
        else $error("calculation length wrong");
    a_start_on_b5: assert property ($rose(busy) |-> $past(wrOp && idx == 3'd5))
        else $error("start without byte5 write");
    a_mul_sequence: assert property ($rose(busy) && op == OP_MUL |-> $past(seq) == SEQ_W041)
        else $error("multiply started from wrong sequence");
    a_div16_sequence: assert property ($rose(busy) && op == OP_DIV16 |-> $past(seq) == SEQ_W014)
        else $error("16/16 divide started from wrong sequence");
    a_div32_sequence: assert property ($rose(busy) && op == OP_DIV32 |-> $past(seq) == SEQ_W01234)
        else $error("32/16 divide started from wrong sequence");
    a_no_stray_start: assert property (!busy && !(wrOp && idx == 3'd5) |=> !busy)
        else $error("calculation started without byte5 write");
    a_err_keep_busy: assert property (hitStat && !we_i && errFlag && busy |=> errFlag)
        else $error("error flag cleared while busy");
    a_ovf_hold: assert property (!done |=> ovfFlag == $past(ovfFlag))
        else $error("overflow changed outside completion");
    a_read_upper_zero: assert property (hitOp && !we_i |=> ack_o && dat_o[31:8] == 24'h00_0000)
        else $error("operand read upper bits not zero");
    a_err_set: assert property (hitOp && busy |=> errFlag)
        else $error("error flag not set on busy access");
    a_err_clear: assert property (hitStat && !we_i && errFlag && !busy |=> !errFlag)
        else $error("error flag not cleared by status read");
    a_err_hold: assert property (errFlag && !(hitStat && !we_i) |=> errFlag)
        else $error("error flag lost");
    a_mul_result: assert property (done && op == OP_MUL |=>
            opFlat[31:0] == $past(mulProd) && ovfFlag == ($past(mulProd) > 32'h0000_ffff))
        else $error("product or overflow wrong");
    a_div_overflow: assert property (done && op != OP_MUL |=> ovfFlag == ($past(divisor) == 16'h0000))
        else $error("divide overflow wrong");
    a_busy_frozen: assert property (busy && !done |=> $stable(opFlat))
        else $error("operands changed during calculation");
    a_status_zero: assert property (hitStat && !we_i |=> ack_o && dat_o[5:0] == 6'b00_0000)
        else $error("status low bits not zero");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");

    c_div32_run: cover property ($rose(busy) && op == OP_DIV32);
    c_div16_run: cover property ($rose(busy) && op == OP_DIV16);
    c_mul_run: cover property ($rose(busy) && op == OP_MUL);
    c_err_seen: cover property ($rose(errFlag));
    c_ovf_seen: cover property ($rose(ovfFlag));

endmodule
`default_nettype wire

//--- mdv_params.svh
// constants of the multiply/divide unit: offsets, fields, resets, timing
`ifndef MDV_PARAMS_SVH
`define MDV_PARAMS_SVH

// ==========================================================================
// register map (byte addresses on the 32-bit bus)
`define MDV_ADR_W 8
`define MDV_OFS_BYTE0 8'h00
`define MDV_OFS_STATUS 8'h18
`define MDV_NUM_BYTES 6

// ==========================================================================
// status fields and reset values
`define MDV_BIT_ERR 7
`define MDV_BIT_OVF 6
`define MDV_STATUS_RESET 8'h00
`define MDV_BYTE_RESET 8'h00

// ==========================================================================
// timing: calculation times in system clock periods
`define MDV_CLK_NS 25
`define MDV_SYSTEM_CLOCK_PERIOD_NS 25
`define MDV_DIV32_SYSTEM_CLOCK_PERIOD 17
`define MDV_DIV16_SYSTEM_CLOCK_PERIOD 9
`define MDV_MUL_SYSTEM_CLOCK_PERIOD 11
`define MDV_CYC(t) (((t) * `MDV_SYSTEM_CLOCK_PERIOD_NS + `MDV_CLK_NS - 1) / `MDV_CLK_NS)
`define MDV_CNT_W 5

`endif

//--- mdv_pkg.sv
// types of the multiply/divide unit
`default_nettype none
package mdv_pkg;
    typedef enum {SEQ_NONE, SEQ_W0, SEQ_W01, SEQ_W012, SEQ_W0123, SEQ_W01234, SEQ_W014, SEQ_W04,
        SEQ_W041} mdv_seq_e;
    typedef enum {OP_DIV32, OP_DIV16, OP_MUL} mdv_op_e;
endpackage
`default_nettype wire

//--- mdv_cpu_model.sv
// cpu-side wishbone master model for the multiply/divide unit
`include "mdv_params.svh"
`timescale 1ns/100ps
`default_nettype none

module mdv_cpu_model (
    input wire logic clk_sys,
    output logic [`MDV_ADR_W-1:0] adr,
    output logic [31:0] datW,
    input wire logic [31:0] datR,
    output logic we,
    output logic [3:0] sel,
    output logic stb,
    output logic cyc,
    input wire logic ack
);
    initial begin
        adr = 8'h00;
        datW = 32'h0000_0000;
        we = 1'b0;
        sel = 4'h0;
        stb = 1'b0;
        cyc = 1'b0;
    end

    // ==========================================================
    // bus cycle
    // request held until ack is sampled high at a rising edge or 16 edges have passed
    task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s,
        output logic [7:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge clk_sys);
        adr <= a;
        we <= w;
        datW <= {24'h00_0000, d};
        sel <= s;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 16);
        ok = (ack === 1'b1);
        q = datR[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        // released lines show the inverse, so a stale request never looks valid
        adr <= ~a;
        datW <= ~{24'h00_0000, d};
    endtask
endmodule
`default_nettype wire

//--- mdv_mul_div_unit_tb.sv
// self-checking bench for the multiply/divide unit
`include "mdv_params.svh"
`timescale 1ns/100ps
`default_nettype none

module mdv_mul_div_unit_tb;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    wire [`MDV_ADR_W-1:0] adr;
    wire [31:0] datW;
    wire [31:0] datR;
    wire we;
    wire [3:0] sel;
    wire stb;
    wire cyc;
    wire ack;
    int mismatches = 0;
    int samplesChecked = 0;
    logic [7:0] mem [6] = '{default: 8'h00};
    logic [47:0] res;
    logic expErr = 1'b0;
    logic expOvf = 1'b0;
    logic busy = 1'b0;
    int lastKind = 0;
    int ordTab [3][6] = '{'{0, 1, 2, 3, 4, 5}, '{0, 1, 4, 5, 0, 0}, '{0, 4, 1, 5, 0, 0}};
    int lenTab [3] = '{6, 4, 4};
    int cycTab [3] = '{`MDV_CYC(`MDV_DIV32_SYSTEM_CLOCK_PERIOD), `MDV_CYC(`MDV_DIV16_SYSTEM_CLOCK_PERIOD), `MDV_CYC(`MDV_MUL_SYSTEM_CLOCK_PERIOD)};
    logic [5:0] maskTab [3] = '{6'h3F, 6'h33, 6'h0F};

    always #12.5 clk_sys = ~clk_sys;

    mdv_mul_div_unit mdv_mul_div_unit_i (.clk_sys(clk_sys), .nrst(nrst), .adr_i(adr), .dat_i(datW),
        .dat_o(datR), .we_i(we), .sel_i(sel), .stb_i(stb), .cyc_i(cyc), .ack_o(ack));
    mdv_cpu_model mdv_cpu_model_i (.clk_sys(clk_sys), .adr(adr), .datW(datW), .datR(datR), .we(we),
        .sel(sel), .stb(stb), .cyc(cyc), .ack(ack));

    // ==========================================================
    // reporting
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samplesChecked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ==========================================================
    // bus access with a shadow of the expected register state
    function automatic logic [7:0] ofs(input int n);
        return 8'(`MDV_OFS_BYTE0 + 4 * n);
    endfunction

    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s,
        output logic [7:0] q);
        logic ok;
        logic opnd;
        opnd = a < `MDV_OFS_STATUS && a[1:0] == 2'b00;
        mdv_cpu_model_i.access(a, w, d, s, q, ok);
        if (!ok) begin
            mismatches++;
            complete_run();
        end
        if (busy && opnd) expErr = 1'b1;
        if (w && s[0] && !busy && opnd) mem[a[4:2]] = d;
        if (!w && a == `MDV_OFS_STATUS && !busy) expErr = 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        logic [7:0] q;
        bus(a, 1'b1, d, s, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        bus(a, 1'b0, 8'h00, 4'hF, q);
        check(what, exp, q);
    endtask

    task automatic check_all();
        rd(`MDV_OFS_STATUS, {expErr, expOvf, 6'h00}, "status");
        for (int i = 0; i < `MDV_NUM_BYTES; i++) rd(ofs(i), mem[i], "data byte");
    endtask

    // ==========================================================
    // operations
    task automatic run_op(input int kind, input logic [31:0] x, input logic [15:0] y);
        logic [7:0] v [6];
        logic [31:0] q;
        logic [15:0] r;
        v = '{x[7:0], x[15:8], x[23:16], x[31:24], y[7:0], y[15:8]};
        for (int i = 0; i < lenTab[kind]; i++) begin
            wr(ofs(ordTab[kind][i]), v[ordTab[kind][i]], 4'h1);
            if (i == 1) rd(8'h1C, 8'h00, "unmapped");
        end
        busy = 1'b1;
        lastKind = kind;
        q = (y == 16'h0000) ? 32'hFFFF_FFFF : x / y;
        r = (y == 16'h0000) ? x[15:0] : 16'(x % y);
        if (kind == 1 && y != 16'h0000) begin
            q = x[15:0] / y;
            r = x[15:0] % y;
        end
        expOvf = (y == 16'h0000);
        if (kind == 2) begin
            q = x[15:0] * y;
            expOvf = q > 32'h0000_FFFF;
        end
        res = {r, q};
    endtask

    task automatic finish_op(input int slack);
        repeat (slack) @(posedge clk_sys);
        for (int i = 0; i < 6; i++) if (maskTab[lastKind][i]) mem[i] = res[8 * i +: 8];
        busy = 1'b0;
    endtask

    task automatic op_test(input int kind, input logic [31:0] x, input logic [15:0] y);
        run_op(kind, x, y);
        finish_op(cycTab[kind] - 2);
        check_all();
        $display("test op %0d %h by %h done", kind, x, y);
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        check_all();
        $display("test reset done");
        op_test(2, 32'h0000_1234, 16'h5678);
        op_test(2, 32'h0000_00FF, 16'h0101);
        op_test(0, 32'h89AB_CDEF, 16'h1234);
        op_test(1, 32'h0000_FFFF, 16'h0007);
        op_test(1, 32'h0000_1234, 16'h0000);
        op_test(0, 32'hFFFF_FFFF, 16'hFFFF);
        op_test(0, 32'h8765_4321, 16'h0000);
        // read lands one cycle before the end of the calculation
        run_op(2, 32'h0000_0002, 16'h0003);
        repeat (cycTab[2] - 4) @(posedge clk_sys);
        rd(ofs(0), mem[0], "busy read");
        finish_op(0);
        check_all();
        check_all();
        $display("test busy read done");
        run_op(2, 32'h0000_0010, 16'h0020);
        wr(ofs(4), 8'hAA, 4'h1);
        finish_op(cycTab[2]);
        check_all();
        $display("test busy write done");
        wr(ofs(0), 8'h11, 4'h1);
        wr(ofs(1), 8'h22, 4'h1);
        wr(ofs(4), 8'h33, 4'h1);
        wr(ofs(2), 8'h44, 4'h1);
        wr(ofs(5), 8'h55, 4'h1);
        rd(ofs(0), 8'h11, "no start");
        wr(`MDV_OFS_STATUS, 8'hFF, 4'h1);
        wr(ofs(3), 8'h66, 4'hE);
        check_all();
        $display("test no start and ignored writes done");
        complete_run();
    end
endmodule
`default_nettype wire
